// ### shared/cc_defines.svh
// Register offsets, field positions, reset values and write masks of the capture/compare channels.
`ifndef CC_DEFINES_SVH
`define CC_DEFINES_SVH
// =====================================================================
// Register byte offsets
`define OFF_CH1_CTRL    8'h24
`define OFF_CH2_CTRL    8'h28
`define OFF_CH3_CTRL    8'h2C
`define OFF_CH1_VAL_A   8'h3C
`define OFF_CH1_VAL_B   8'h40
`define OFF_CH2_VAL_A   8'h44
`define OFF_CH2_VAL_B   8'h48
`define OFF_CH3_VAL_A   8'h4C
`define OFF_CH3_VAL_B   8'h50
`define OFF_CH4_VAL     8'h54
`define OFF_CH4_CTRL    8'h58
// =====================================================================
// Channel 1..3 control fields
`define F_FORCE_B       15
`define F_FORCE_A       14
`define F_DMA_B         11
`define F_DMA_A         10
`define F_IRQ_B         9
`define F_IRQ_A         8
`define F_PRE_B         7
`define F_PRE_A         6
`define F_FUNC_B        5
`define F_FUNC_A        4
`define F_SEL_B_HI      3
`define F_SEL_B_LO      2
`define F_SEL_A_HI      1
`define F_SEL_A_LO      0
`define CTRL_RESET      16'h3000
`define CTRL_RW_MASK    16'h3FFF
// Channel 4 control fields
`define F4_EN           5
`define F4_CENTER_HI    4
`define F4_CENTER_LO    3
`define F4_DMA          2
`define F4_IRQ          1
`define F4_PRE          0
`define CTRL4_RESET     16'h0000
`define CTRL4_MASK      16'h003F
`define VAL_RESET       16'h0000
// Edge select codes
`define EDGE_RISE       2'h1
`define EDGE_FALL       2'h2
`define EDGE_BOTH       2'h3
// Brake level codes
`define BRK_HIZ         2'h0
`define BRK_KEEP        2'h1
`define BRK_LOW         2'h2
`define BRK_HIGH        2'h3
`endif

// ### shared/cc_pkg.sv
// Types shared by the capture/compare channel block.
package cc_pkg;
	// =====================================================================
	// Request bundle from one sub-channel.
	typedef struct packed {
		logic irq;
		logic dma;
	} req_t;
	// Brake drive of one output: enable and level.
	typedef struct packed {
		logic oe;
		logic level;
	} brake_drive_t;
endpackage

// ### verilog/timer_channel_capture_compare.sv
// Capture/compare channel control for a 16-bit timer, APB slave with channels 1 to 4.
//
// Our own choice: register access over APB.
`include "cc_defines.svh"
module timer_channel_capture_compare #(
	parameter int CNT_W = 16
) (
	input  wire logic                        sys_clk,
	input  wire logic                        resetn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [CNT_W-1:0]            counter,
	input  wire logic                        count_down,
	input  wire logic                        center_mode,
	input  wire logic                        update_event,
	input  wire logic                        brake_active,
	input  wire logic [5:0]                  capture_in,
	input  wire logic [6:0]                  compare_match,
	output logic      [6:0][CNT_W-1:0]       active_value,
	output cc_pkg::brake_drive_t [5:0]       brake_drive,
	output logic                             timer_irq,
	output logic      [6:0]                  dma_req,
	output logic                             ch4_compare_en
);
	// =====================================================================
	// Parameter check at elaboration: value registers and bus lanes are 16 bits wide.
	if (CNT_W != 16) begin : g_bad_width
		$error("Counter width must be 16");
	end

	// =====================================================================
	// Decode helpers. Index 0..5: ch1A, ch1B, ch2A, ch2B, ch3A, ch3B; 6: ch4.
	function automatic logic [7:0] val_off(input int i);
		case (i)
			0: val_off = `OFF_CH1_VAL_A;
			1: val_off = `OFF_CH1_VAL_B;
			2: val_off = `OFF_CH2_VAL_A;
			3: val_off = `OFF_CH2_VAL_B;
			4: val_off = `OFF_CH3_VAL_A;
			5: val_off = `OFF_CH3_VAL_B;
			default: val_off = `OFF_CH4_VAL;
		endcase
	endfunction

	function automatic logic [7:0] ctrl_off(input int c);
		case (c)
			0: ctrl_off = `OFF_CH1_CTRL;
			1: ctrl_off = `OFF_CH2_CTRL;
			default: ctrl_off = `OFF_CH3_CTRL;
		endcase
	endfunction

	// Edge detection for a given capture select code.
	function automatic logic edge_hit(input logic [1:0] sel, input logic rise, input logic fall);
		edge_hit = ((sel == `EDGE_RISE) && rise) || ((sel == `EDGE_FALL) && fall) ||
			((sel == `EDGE_BOTH) && (rise || fall));
	endfunction

	// =====================================================================
	// APB access strobes. Zero wait states; unmapped addresses answer an error.
	logic wr_access;
	logic rd_access;
	logic ch4_ctrl_hit;
	logic [2:0] ctrl_hit;
	logic [6:0] val_hit;
	assign wr_access    = psel && penable && pwrite;
	assign rd_access    = psel && penable && !pwrite;
	assign ch4_ctrl_hit = (paddr == `OFF_CH4_CTRL);
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && !(|ctrl_hit || |val_hit || ch4_ctrl_hit);

	// =====================================================================
	// Channel 4 control register.
	logic [15:0] ctrl4_q;
	logic [15:0] ctrl4_d;
	assign ctrl4_d = (wr_access && ch4_ctrl_hit) ? (pwdata[15:0] & `CTRL4_MASK) : ctrl4_q;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			ctrl4_q <= `CTRL4_RESET;
		end else begin
			ctrl4_q <= ctrl4_d;
		end
	end
	assign ch4_compare_en = ctrl4_q[`F4_EN];

	// =====================================================================
	// Channels 1..3: identical control registers and two sub-channels each.
	logic [2:0][15:0] ctrl_q;
	logic [6:0][15:0] shadow_q;
	logic [6:0][15:0] active_q;
	logic [5:0]       cap_prev_q;
	logic [5:0]       force_q;
	logic [6:0]       event_w;
	logic [6:0]       preload_w;
	logic [6:0]       capture_w;
	cc_pkg::req_t [6:0] req_q;

	genvar c;
	generate
		for (c = 0; c < 3; c++) begin : g_ctrl
			assign ctrl_hit[c] = (paddr == ctrl_off(c));
			// Force bits clear themselves one cycle after being written.
			logic [15:0] cd;
			assign cd = (wr_access && ctrl_hit[c]) ? pwdata[15:0] :
				{2'b00, ctrl_q[c][13:0]};
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					ctrl_q[c] <= `CTRL_RESET;
				end else begin
					ctrl_q[c] <= cd;
				end
			end
			assign force_q[2*c]   = ctrl_q[c][`F_FORCE_A];
			assign force_q[2*c+1] = ctrl_q[c][`F_FORCE_B];
		end
	endgenerate

	genvar s;
	generate
		for (s = 0; s < 6; s++) begin : g_sub
			localparam int CH = s / 2;
			localparam bit IS_B = (s % 2) == 1;
			logic       capture_mode;
			logic [1:0] sel;
			logic       irq_en;
			logic       dma_en;
			logic       rise;
			logic       fall;
			logic       cap_hit;
			// Field selection differs only in bit positions between A and B.
			assign capture_mode = IS_B ? ctrl_q[CH][`F_FUNC_B] : ctrl_q[CH][`F_FUNC_A];
			assign capture_w[s] = capture_mode;
			assign sel = IS_B ? ctrl_q[CH][`F_SEL_B_HI:`F_SEL_B_LO] :
				ctrl_q[CH][`F_SEL_A_HI:`F_SEL_A_LO];
			assign preload_w[s] = !capture_mode &&
				(IS_B ? ctrl_q[CH][`F_PRE_B] : ctrl_q[CH][`F_PRE_A]);
			assign irq_en = IS_B ? ctrl_q[CH][`F_IRQ_B] : ctrl_q[CH][`F_IRQ_A];
			assign dma_en = IS_B ? ctrl_q[CH][`F_DMA_B] : ctrl_q[CH][`F_DMA_A];
			assign rise = capture_in[s] && !cap_prev_q[s];
			assign fall = !capture_in[s] && cap_prev_q[s];
			assign cap_hit = capture_mode && (edge_hit(sel, rise, fall) || force_q[s]);
			assign event_w[s] = cap_hit ||
				(!capture_mode && (compare_match[s] || force_q[s]));
			// Brake drive in compare mode: off for codes 00 and 01, low or high.
			always_comb begin
				brake_drive[s] = '{oe: 1'b0, level: 1'b0};
				if (brake_active && !capture_mode) begin
					case (sel)
						`BRK_LOW:  brake_drive[s] = '{oe: 1'b1, level: 1'b0};
						`BRK_HIGH: brake_drive[s] = '{oe: 1'b1, level: 1'b1};
						default:   brake_drive[s] = '{oe: 1'b0, level: 1'b0};
					endcase
				end
			end
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					cap_prev_q[s] <= 1'b0;
					req_q[s]      <= '0;
				end else begin
					cap_prev_q[s] <= capture_in[s];
					// Requests follow the event by one cycle, the same edge that stores the capture.
					req_q[s].irq <= event_w[s] && irq_en;
					req_q[s].dma <= event_w[s] && dma_en;
				end
			end
		end
	endgenerate

	// =====================================================================
	// Channel 4 interrupt: plain match, or in centre mode only the selected direction; the DMA request is not filtered.
	logic [1:0] center_irq_sel;
	logic       ch4_dir_ok;
	assign center_irq_sel = ctrl4_q[`F4_CENTER_HI:`F4_CENTER_LO];
	assign ch4_dir_ok = !center_mode || (center_irq_sel[0] && !count_down) ||
		(center_irq_sel[1] && count_down);
	assign event_w[6] = compare_match[6] && ctrl4_q[`F4_EN];
	assign preload_w[6] = ctrl4_q[`F4_PRE];
	assign capture_w[6] = 1'b0;
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			req_q[6] <= '0;
		end else begin
			req_q[6].irq <= event_w[6] && ctrl4_q[`F4_IRQ] && ch4_dir_ok;
			req_q[6].dma <= event_w[6] && ctrl4_q[`F4_DMA];
		end
	end

	// =====================================================================
	// Value registers: shadow takes writes, active feeds compare and holds captures.
	genvar v;
	generate
		for (v = 0; v < 7; v++) begin : g_val
			logic wr;
			logic cap;
			assign val_hit[v] = (paddr == val_off(v));
			assign wr  = wr_access && val_hit[v];
			assign cap = event_w[v] && capture_w[v];
			always_ff @(posedge sys_clk) begin
				if (!resetn) begin
					shadow_q[v] <= `VAL_RESET;
					active_q[v] <= `VAL_RESET;
				end else begin
					if (wr) begin
						shadow_q[v] <= pwdata[15:0];
					end
					if (cap) begin
						active_q[v] <= counter;
						shadow_q[v] <= counter;
					end else if (wr && !preload_w[v]) begin
						active_q[v] <= pwdata[15:0];
					end else if (update_event && preload_w[v]) begin
						active_q[v] <= shadow_q[v];
					end
				end
			end
			assign active_value[v] = active_q[v];
		end
	endgenerate

	// =====================================================================
	// Read mux; upper bits read as zero.
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_access) begin
			for (int i = 0; i < 3; i++) begin
				if (ctrl_hit[i]) begin
					prdata = {16'h0000, ctrl_q[i]};
				end
			end
			for (int j = 0; j < 7; j++) begin
				if (val_hit[j]) begin
					prdata = {16'h0000, shadow_q[j]};
				end
			end
			if (ch4_ctrl_hit) begin
				prdata = {16'h0000, ctrl4_q};
			end
		end
	end

	// =====================================================================
	// Request outputs.
	always_comb begin
		timer_irq = 1'b0;
		for (int k = 0; k < 7; k++) begin
			timer_irq = timer_irq | req_q[k].irq;
			dma_req[k] = req_q[k].dma;
		end
	end

	// =====================================================================
	// Assertions.
	property p_dma_a;
		@(posedge sys_clk) disable iff (!resetn)
			(event_w[0] && ctrl_q[0][`F_DMA_A]) |=> dma_req[0];
	endproperty
	a_dma_a: assert property (p_dma_a) else $error("A event lost its DMA request");

	property p_dma_b_off;
		@(posedge sys_clk) disable iff (!resetn)
			(!ctrl_q[0][`F_DMA_B]) |=> !dma_req[1];
	endproperty
	a_dma_b_off: assert property (p_dma_b_off) else $error("B DMA raised while disabled");

	property p_irq_b;
		@(posedge sys_clk) disable iff (!resetn)
			(event_w[1] && ctrl_q[0][`F_IRQ_B]) |=> timer_irq;
	endproperty
	a_irq_b: assert property (p_irq_b) else $error("B event did not interrupt");

	property p_irq_a;
		@(posedge sys_clk) disable iff (!resetn)
			(event_w[0] && ctrl_q[0][`F_IRQ_A]) |=> timer_irq;
	endproperty
	a_irq_a: assert property (p_irq_a) else $error("A event did not interrupt");

	sequence s_capture_edge;
		ctrl_q[0][`F_FUNC_A] && event_w[0];
	endsequence
	property p_capture;
		@(posedge sys_clk) disable iff (!resetn)
			s_capture_edge |=> (active_value[0] == $past(counter));
	endproperty
	a_capture: assert property (p_capture) else $error("Capture did not store counter");

	property p_preload_hold;
		@(posedge sys_clk) disable iff (!resetn)
			(preload_w[1] && !update_event && !event_w[1]) |=> $stable(active_value[1]);
	endproperty
	a_preload_hold: assert property (p_preload_hold) else $error("Buffered B changed early");

	property p_preload_load;
		@(posedge sys_clk) disable iff (!resetn)
			(preload_w[0] && update_event && !event_w[0]) |=> (active_value[0] == $past(shadow_q[0]));
	endproperty
	a_preload_load: assert property (p_preload_load) else $error("Update did not load A");

	property p_force_clear;
		@(posedge sys_clk) disable iff (!resetn)
			force_q[0] |=> (!force_q[0] || $past(wr_access && ctrl_hit[0]));
	endproperty
	a_force_clear: assert property (p_force_clear) else $error("Force bit did not self-clear");

	property p_brake_high;
		@(posedge sys_clk) disable iff (!resetn)
			(brake_active && !ctrl_q[0][`F_FUNC_A] && ctrl_q[0][1:0] == `BRK_HIGH)
				|-> (brake_drive[0].oe && brake_drive[0].level);
	endproperty
	a_brake_high: assert property (p_brake_high) else $error("Brake high not driven");

	property p_ch4_dma;
		@(posedge sys_clk) disable iff (!resetn)
			(event_w[6] && ctrl4_q[`F4_DMA]) |=> dma_req[6];
	endproperty
	a_ch4_dma: assert property (p_ch4_dma) else $error("Channel 4 DMA missing");

	property p_ch4_center;
		@(posedge sys_clk) disable iff (!resetn)
			(center_mode && ctrl4_q[`F4_CENTER_HI:`F4_CENTER_LO] == 2'h0) |=> !req_q[6].irq;
	endproperty
	a_ch4_center: assert property (p_ch4_center) else $error("Channel 4 irq with no direction");
endmodule

// ### dv/cc_far_side.sv
// Far-side model: channel input pins, outside comparators and the DMA controller.
module cc_far_side (
	input  wire logic       sys_clk,
	input  wire logic [6:0] dma_req,
	output logic      [5:0] capture_in,
	output logic      [6:0] compare_match
);
	timeunit 1ns;
	timeprecision 1ps;
	int dma_taken = 0;
	// =====================================================================
	// Pins start low so that the first selected edge is a rising one.
	initial begin
		capture_in = 6'h00;
		compare_match = 7'h00;
	end
	// The DMA controller accepts every one-cycle request and never stalls.
	always @(posedge sys_clk) begin
		dma_taken <= dma_taken + $countones(dma_req);
	end
	// Moves one pin just after an edge; the block sees it in the following cycle.
	task automatic set_pin(input int k, input logic v);
		@(posedge sys_clk);
		capture_in[k] <= v;
	endtask
	// One-cycle comparator match pulse.
	task automatic pulse_match(input int k);
		@(posedge sys_clk);
		compare_match[k] <= 1'b1;
		@(posedge sys_clk);
		compare_match[k] <= 1'b0;
	endtask
endmodule

// ### dv/timer_channel_capture_compare_test.sv
// Self-checking bench for the capture/compare channel block.
module timer_channel_capture_compare_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic                       sys_clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic                       count_down, center_mode, update_event, brake_active;
	logic                       timer_irq, ch4_compare_en, er;
	logic [7:0]                 paddr;
	logic [31:0]                pwdata, prdata, rd;
	logic [15:0]                counter;
	logic [5:0]                 capture_in;
	logic [6:0]                 compare_match, dma_req;
	logic [6:0][15:0]           active_value;
	cc_pkg::brake_drive_t [5:0] brake_drive;
	logic [15:0]                ea [7];
	int                         miscompares, n_checks, ndma;

	timer_channel_capture_compare timer_channel_capture_compare_i (
		.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .counter(counter), .count_down(count_down),
		.center_mode(center_mode), .update_event(update_event),
		.brake_active(brake_active), .capture_in(capture_in),
		.compare_match(compare_match), .active_value(active_value),
		.brake_drive(brake_drive), .timer_irq(timer_irq), .dma_req(dma_req),
		.ch4_compare_en(ch4_compare_en));
	cc_far_side cc_far_side_i (.sys_clk(sys_clk), .dma_req(dma_req),
		.capture_in(capture_in), .compare_match(compare_match));

	// =====================================================================
	// Clock at 100 MHz.
	initial sys_clk = 1'b0;
	always #5 sys_clk = ~sys_clk;

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// DMA checks also add up the expected requests, so the far side's total can be held to it.
	task automatic chk_dma(input string nm, input logic [6:0] e);
		ndma += $countones(e);
		chk(nm, 32'(e), 32'(dma_req));
	endtask

	task automatic end_of_test;
		if (miscompares == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) break;
		end
		if (n == 16) begin
			miscompares++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function automatic logic [7:0] ca(input int k);
		return (k == 6) ? 8'h58 : 8'h24 + 8'(4 * (k / 2));
	endfunction

	function automatic logic [7:0] va(input int k);
		return 8'h3C + 8'(4 * k);
	endfunction

	// Control word for one sub-channel; channel 4 always keeps its enable set.
	function automatic logic [31:0] ctl(input int k, input logic p, input logic ie,
		input logic de, input logic f, input logic [1:0] s);
		int b;
		b = k % 2;
		if (k == 6) return {26'h0, 1'b1, 2'h0, de, ie, p};
		return (32'(de) << (10 + b)) | (32'(ie) << (8 + b)) | (32'(p) << (6 + b))
			| (32'(f) << (4 + b)) | (32'(s) << (2 * b));
	endfunction

	function automatic logic cap_hit(input logic [1:0] c, input logic rise);
		return (c == 2'h3) || (c == (rise ? 2'h1 : 2'h2));
	endfunction

	// Main sequence.
	initial begin
		logic [31:0] m;
		logic [15:0] v1, v2;
		logic [1:0]  c;
		logic        p, ie, de, hit;
		int          k, j;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{counter, count_down, center_mode, update_event, brake_active} = '0;
		miscompares = 0;
		n_checks = 0;
		ndma = 0;
		resetn = 1'b0;
		void'($urandom(32'h53909EE3));
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		// Reset values first, before any write disturbs a shared register.
		for (k = 0; k < 7; k++) begin
			apb(1'b0, ca(k), 32'h0);
			chk("ctrl reset", (k < 6) ? 32'h3000 : 32'h0, rd);
			apb(1'b0, va(k), 32'h0);
			chk("value reset", 32'h0, rd);
		end
		// Random read-back; force bits stay clear since the written word masks them out.
		for (k = 0; k < 7; k++) begin
			m = $urandom & 32'hFFFF3FFF;
			apb(1'b1, ca(k), m);
			apb(1'b0, ca(k), 32'h0);
			chk("ctrl rw", m & ((k < 6) ? 32'h3FFF : 32'h3F), rd);
			m = $urandom;
			apb(1'b1, va(k), m);
			apb(1'b0, va(k), 32'h0);
			chk("value rw", m & 32'hFFFF, rd);
		end
		apb(1'b1, 8'h30, 32'hFFFF);
		chk("unmapped write err", 32'h1, er);
		apb(1'b0, 8'h30, 32'h0);
		chk("unmapped read", 32'h0, rd);
		// Compare mode: direct and buffered loads, then a comparator match.
		for (k = 0; k < 7; k++) begin
			for (j = 0; j < 2; j++) begin
				p = 1'(j);
				v1 = 16'($urandom);
				v2 = 16'($urandom);
				ie = 1'($urandom);
				de = 1'($urandom);
				apb(1'b1, ca(k), ctl(k, 1'b0, 1'b0, 1'b0, 1'b0, 2'h0));
				apb(1'b1, va(k), {16'h0, v1});
				apb(1'b1, ca(k), ctl(k, p, ie, de, 1'b0, 2'h0));
				apb(1'b1, va(k), {16'h0, v2});
				#1;
				chk("active before update", p ? v1 : v2, active_value[k]);
				@(posedge sys_clk);
				update_event <= 1'b1;
				@(posedge sys_clk);
				update_event <= 1'b0;
				#1;
				chk("active after update", v2, active_value[k]);
				cc_far_side_i.pulse_match(k);
				#1;
				chk("match irq", ie, timer_irq);
				chk_dma("match dma", 7'(32'(de) << k));
				ea[k] = v2;
			end
		end
		// Capture mode: every edge code against a rising and then a falling edge.
		for (k = 0; k < 6; k++) begin
			for (j = 0; j < 8; j++) begin
				c = 2'(j >> 1);
				ie = 1'($urandom);
				de = 1'($urandom);
				v1 = 16'($urandom);
				apb(1'b1, ca(k), ctl(k, 1'b0, ie, de, 1'b1, c));
				@(posedge sys_clk);
				counter <= v1;
				cc_far_side_i.set_pin(k, ~j[0]);
				@(posedge sys_clk);
				#1;
				hit = cap_hit(c, ~j[0]);
				if (hit) ea[k] = v1;
				chk("capture value", ea[k], active_value[k]);
				chk("capture irq", hit & ie, timer_irq);
				chk_dma("capture dma", 7'(32'(hit & de) << k));
			end
		end
		// Software force: compare mode only requests, capture mode also takes the counter.
		for (k = 0; k < 6; k++) begin
			for (j = 0; j < 2; j++) begin
				ie = 1'($urandom);
				de = 1'(j) & 1'($urandom);
				v1 = 16'($urandom);
				@(posedge sys_clk);
				counter <= v1;
				apb(1'b1, ca(k), ctl(k, 1'b0, ie, de, 1'(j), 2'h0) | (32'h4000 << (k % 2)));
				@(posedge sys_clk);
				#1;
				if (j == 1) ea[k] = v1;
				chk("force value", ea[k], active_value[k]);
				chk("force irq", ie, timer_irq);
				chk_dma("force dma", 7'(32'(de) << k));
				apb(1'b0, ca(k), 32'h0);
				chk("force self-clear", 32'h0, rd & 32'hC000);
			end
		end
		// Brake levels: codes 00 and 01 leave the pin undriven here.
		@(posedge sys_clk);
		brake_active <= 1'b1;
		for (k = 0; k < 6; k++) begin
			for (j = 0; j < 4; j++) begin
				apb(1'b1, ca(k), ctl(k, 1'b0, 1'b0, 1'b0, 1'b0, 2'(j)));
				#1;
				chk("brake oe", j >> 1, brake_drive[k].oe);
				if (j > 1) chk("brake level", j & 1, brake_drive[k].level);
			end
		end
		// Channel 4 centre-aligned filter of the match interrupt, both directions.
		for (j = 0; j < 8; j++) begin
			c = 2'(j >> 1);
			@(posedge sys_clk);
			brake_active <= 1'b0;
			center_mode <= 1'b1;
			count_down <= j[0];
			apb(1'b1, 8'h58, {26'h0, 1'b1, c, 1'b1, 1'b1, 1'b0});
			cc_far_side_i.pulse_match(6);
			#1;
			chk("centre irq", c[j[0]], timer_irq);
			chk_dma("ch4 dma", 7'h40);
			chk("ch4 enable", 32'h1, ch4_compare_en);
		end
		// A stray request that no check expected shows up in the far side's total.
		@(posedge sys_clk);
		#1;
		chk("dma total", 32'(ndma), 32'(cc_far_side_i.dma_taken));
		end_of_test();
	end
endmodule
